// ---- rtl/hs_pwm_pkg.sv ----
package hs_pwm_pkg;

    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    localparam logic [6:0] SRC_SEL_56_ADDR = 7'h16;
    localparam logic [6:0] DUTY_CH1_ADDR   = 7'h18;
    localparam logic [6:0] DUTY_CH2_ADDR   = 7'h19;
    localparam logic [6:0] DUTY_CH3_ADDR   = 7'h1a;
    localparam logic [6:0] DUTY_CH4_ADDR   = 7'h1b;
    localparam logic [6:0] RATE_SEL_ADDR   = 7'h1c;
    localparam logic [6:0] SCRATCH_ADDR    = 7'h1e;

    localparam logic [7:0] SRC_SEL_56_RST = 8'h00;
    localparam logic [7:0] DUTY_RST       = 8'h00;
    localparam logic [7:0] RATE_SEL_RST   = 8'h00;
    localparam logic [7:0] SCRATCH_RST    = 8'h00;

    localparam logic [7:0] SRC_SEL_56_MASK = 8'h77;
    localparam logic [7:0] RATE_SEL_MASK   = 8'h55;

    localparam int unsigned SW5_SRC_LSB = 0;
    localparam int unsigned SW6_SRC_LSB = 4;
    localparam int unsigned RATE_CH1_BIT = 0;
    localparam int unsigned RATE_STRIDE  = 2;

    localparam logic [2:0] SRC_OFF    = 3'h0;
    localparam logic [2:0] SRC_ON     = 3'h1;
    localparam logic [2:0] SRC_TIMER_SOURCE_ONE = 3'h2;
    localparam logic [2:0] SRC_TIMER_SOURCE_TWO = 3'h3;

    localparam longint unsigned CLK_HZ      = 40000000;
    localparam longint unsigned RATE_SLOW_HZ = 150;
    localparam longint unsigned RATE_FAST_HZ = 300;
    localparam int unsigned PWM_STEPS = 256;
    // clocks per duty step at 300 Hz; 150 Hz uses twice this
    localparam int unsigned FAST_STEP_CYCLES =
        int'(CLK_HZ / (RATE_FAST_HZ * PWM_STEPS));
    localparam int unsigned SLOW_STEP_CYCLES =
        int'(CLK_HZ / (RATE_SLOW_HZ * PWM_STEPS));

endpackage

// ---- rtl/pwm_channel.sv ----
module pwm_channel
    import hs_pwm_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = FAST_STEP_CYCLES
) (
    input  wire logic       core_clk,
    input  wire logic       srst,
    input  wire logic       step_en,
    input  wire logic       slow_sel,
    input  wire logic [7:0] duty,
    output logic            pwm_out
);

    initial begin
        if (STEP_CYCLES < 1) $error("step_cycles must be at least 1");
    end

    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic       half_reg;
    logic       half_next;
    logic       out_reg;
    logic       out_next;

    // slow rate advances only every second step pulse
    always_comb begin
        count_next = count_reg;
        half_next  = half_reg;
        if (step_en) begin
            half_next = ~half_reg;
            if (!slow_sel || half_reg) begin
                count_next = count_reg + 8'h01;
            end
        end
        // all ones must be fully on, so 8'hff overrides the compare
        out_next = (duty == 8'hff) || (count_reg < duty);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_reg <= 8'h00;
            half_reg  <= 1'b0;
            out_reg   <= 1'b0;
        end else begin
            count_reg <= count_next;
            half_reg  <= half_next;
            out_reg   <= out_next;
        end
    end

    assign pwm_out = out_reg;

endmodule // pwm_channel

// ---- rtl/high_side_pwm_config.sv ----
// Operation
// - source codes: off, on, timers, four PWM
// - faults clear source; supply faults unless recovery
// - unused source and rate bits read zero
// - duty byte: zero off, ones on
// - per channel rate bit, 150/300 Hz
// - duty cleared by reset, kept on restart
// - rate cleared by reset, kept on restart
// - scratch byte, read-write, no function
// - scratch reachable only in normal mode
// - hardware never changes scratch byte
// - scratch survives fail-safe and restart
// - scratch clears only on reset events
module high_side_pwm_config
    import hs_pwm_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              srst,
    input  wire logic              restart_mode,
    input  wire logic              normal_mode,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic [1:0]        overcurrent,
    input  wire logic [1:0]        overtemp,
    input  wire logic              supply_fault,
    input  wire logic [1:0]        recovery_en,
    input  wire logic              timer_source_one,
    input  wire logic              timer_source_two,
    output logic                   high_side_switch_five,
    output logic                   high_side_switch_six,
    output logic [3:0]             pwm_level
);
    import hs_pwm_pkg::*;

    logic [7:0] src_sel_reg;
    logic [7:0] src_sel_next;
    logic [7:0] duty_reg [4];
    logic [7:0] duty_next [4];
    logic [7:0] rate_reg;
    logic [7:0] rate_next;
    logic [7:0] scratch_reg;
    logic [7:0] scratch_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [1:0] sw_reg;
    logic [1:0] sw_next;
    logic [15:0] div_reg;
    logic [15:0] div_next;
    logic        step_en;
    logic [3:0]  pwm_raw;

    function automatic logic pick_source(input logic [2:0] code, input logic [3:0] pwm,
                                         input logic t1, input logic t2);
        case (code)
            SRC_OFF:    pick_source = 1'b0;
            SRC_ON:     pick_source = 1'b1;
            SRC_TIMER_SOURCE_ONE: pick_source = t1;
            SRC_TIMER_SOURCE_TWO: pick_source = t2;
            default:    pick_source = pwm[code[1:0]];
        endcase
    endfunction

    // register writes and faults
    always_comb begin
        logic [1:0] clr;
        clr          = 2'b00;
        src_sel_next = src_sel_reg;
        rate_next    = rate_reg;
        scratch_next = scratch_reg;
        for (int i = 0; i < 4; i++) begin
            duty_next[i] = duty_reg[i];
        end
        if (reg_wr) begin
            case (reg_addr)
                SRC_SEL_56_ADDR: src_sel_next = reg_wdata & SRC_SEL_56_MASK;
                DUTY_CH1_ADDR:   duty_next[0] = reg_wdata;
                DUTY_CH2_ADDR:   duty_next[1] = reg_wdata;
                DUTY_CH3_ADDR:   duty_next[2] = reg_wdata;
                DUTY_CH4_ADDR:   duty_next[3] = reg_wdata;
                RATE_SEL_ADDR:   rate_next = reg_wdata & RATE_SEL_MASK;
                SCRATCH_ADDR: begin
                    if (normal_mode) begin
                        scratch_next = reg_wdata;
                    end
                end
                default: ;
            endcase
        end
        // fault clear wins over a write in the same cycle, the safe side
        for (int s = 0; s < 2; s++) begin
            clr[s] = overcurrent[s] || overtemp[s] || (supply_fault && !recovery_en[s]);
        end
        if (clr[0]) begin
            src_sel_next[SW5_SRC_LSB +: 3] = SRC_OFF;
        end
        if (clr[1]) begin
            src_sel_next[SW6_SRC_LSB +: 3] = SRC_OFF;
        end
        // restart clears only the source selection
        if (restart_mode) begin
            src_sel_next = SRC_SEL_56_RST;
        end
    end

    // read mux, registered data
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                SRC_SEL_56_ADDR: rdata_next = src_sel_reg & SRC_SEL_56_MASK;
                DUTY_CH1_ADDR:   rdata_next = duty_reg[0];
                DUTY_CH2_ADDR:   rdata_next = duty_reg[1];
                DUTY_CH3_ADDR:   rdata_next = duty_reg[2];
                DUTY_CH4_ADDR:   rdata_next = duty_reg[3];
                RATE_SEL_ADDR:   rdata_next = rate_reg & RATE_SEL_MASK;
                SCRATCH_ADDR:    rdata_next = normal_mode ? scratch_reg : 8'h00;
                default:         rdata_next = 8'h00;
            endcase
        end else begin
            rdata_next = rdata_reg;
        end
    end

    // step divider at the fast rate
    always_comb begin
        if (div_reg == 16'(FAST_STEP_CYCLES - 1)) begin
            div_next = 16'h0000;
        end else begin
            div_next = div_reg + 16'h0001;
        end
        step_en = (div_reg == 16'(FAST_STEP_CYCLES - 1));
    end

    // switch multiplexer
    always_comb begin
        sw_next[0] = pick_source(src_sel_reg[SW5_SRC_LSB +: 3], pwm_raw,
                                 timer_source_one, timer_source_two);
        sw_next[1] = pick_source(src_sel_reg[SW6_SRC_LSB +: 3], pwm_raw,
                                 timer_source_one, timer_source_two);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            src_sel_reg <= SRC_SEL_56_RST;
            rate_reg    <= RATE_SEL_RST;
            scratch_reg <= SCRATCH_RST;
            for (int i = 0; i < 4; i++) begin
                duty_reg[i] <= DUTY_RST;
            end
            rdata_reg <= 8'h00;
            sw_reg    <= 2'b00;
            div_reg   <= 16'h0000;
        end else begin
            src_sel_reg <= src_sel_next;
            rate_reg    <= rate_next;
            scratch_reg <= scratch_next;
            for (int i = 0; i < 4; i++) begin
                duty_reg[i] <= duty_next[i];
            end
            rdata_reg <= rdata_next;
            sw_reg    <= sw_next;
            div_reg   <= div_next;
        end
    end

    for (genvar c = 0; c < 4; c++) begin : g_ch
        pwm_channel #(
            .STEP_CYCLES (FAST_STEP_CYCLES)
        ) u_ch (
            .core_clk (core_clk),
            .srst     (srst),
            .step_en  (step_en),
            .slow_sel (~rate_reg[RATE_CH1_BIT + RATE_STRIDE * c]),
            .duty     (duty_reg[c]),
            .pwm_out  (pwm_raw[c])
        );
    end

    assign reg_rdata             = rdata_reg;
    assign high_side_switch_five = sw_reg[0];
    assign high_side_switch_six  = sw_reg[1];
    assign pwm_level             = pwm_raw;

endmodule // high_side_pwm_config

// ---- testbench/timer_src_model.sv ----
module timer_src_model (
    input  wire logic core_clk,
    input  wire logic hold,
    output logic      timer_one,
    output logic      timer_two
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg = 4'h0;
    initial begin
        timer_one = 1'b0;
        timer_two = 1'b1;
    end
    // unrelated toggle rates so a swapped timer select shows up
    always @(posedge core_clk) begin
        #1;
        if (!hold) begin
            cnt_reg = cnt_reg + 4'h1;
            timer_one = (cnt_reg[1:0] == 2'h0) ? !timer_one : timer_one;
            timer_two = (cnt_reg == 4'h5) ? !timer_two : timer_two;
        end
    end
endmodule // timer_src_model

// ---- testbench/high_side_pwm_config_assertions.sv ----
module high_side_pwm_config_assertions
    import hs_pwm_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              srst,
    input wire logic              restart_mode,
    input wire logic              normal_mode,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [1:0]        overcurrent,
    input wire logic [1:0]        overtemp,
    input wire logic              supply_fault,
    input wire logic [1:0]        recovery_en,
    input wire logic              high_side_switch_five,
    input wire logic              high_side_switch_six,
    input wire logic [3:0]        pwm_level
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence src_wr(logic [7:0] v);
        reg_wr && reg_addr == SRC_SEL_56_ADDR && (reg_wdata & 8'h77) == v;
    endsequence
    sequence quiet;
        !restart_mode && overcurrent == 2'h0 && overtemp == 2'h0 && !supply_fault;
    endsequence
    chk_src_on_both: assert property (src_wr(8'h11) and quiet |-> ##2
        high_side_switch_five && high_side_switch_six) else $error("switch not on");
    chk_src_off_both: assert property (src_wr(8'h00) |-> ##2
        !high_side_switch_five && !high_side_switch_six) else $error("switch not off");
    chk_oc_five_off: assert property (overcurrent[0] |-> ##2 !high_side_switch_five)
        else $error("overcurrent kept five on");
    chk_ot_six_off: assert property (overtemp[1] |-> ##2 !high_side_switch_six)
        else $error("overtemp kept six on");
    chk_supply_five_off: assert property (supply_fault && !recovery_en[0] |-> ##2
        !high_side_switch_five) else $error("supply fault kept five on");
    chk_scratch_gated: assert property (reg_rd && reg_addr == SCRATCH_ADDR && !normal_mode
        |=> reg_rdata == 8'h00) else $error("scratch read outside normal mode");
    chk_src_rsvd_zero: assert property (reg_rd && reg_addr == SRC_SEL_56_ADDR
        |=> (reg_rdata & 8'h88) == 8'h00) else $error("source reserved bits set");
    chk_rate_rsvd_zero: assert property (reg_rd && reg_addr == RATE_SEL_ADDR
        |=> (reg_rdata & 8'haa) == 8'h00) else $error("rate reserved bits set");
    chk_reset_clear: assert property (disable iff (1'b0) srst |=> reg_rdata == 8'h00 &&
        !high_side_switch_five && pwm_level == 4'h0) else $error("reset left state");
    chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
endmodule // high_side_pwm_config_assertions
bind high_side_pwm_config high_side_pwm_config_assertions i_chk (.*);

// ---- testbench/test_high_side_pwm_config.sv ----
module test_high_side_pwm_config;
    import hs_pwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic        restart_mode = 1'b0;
    logic        normal_mode = 1'b1;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [6:0]  reg_addr = 7'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [1:0]  overcurrent = 2'h0;
    logic [1:0]  overtemp = 2'h0;
    logic        supply_fault = 1'b0;
    logic [1:0]  recovery_en = 2'h0;
    logic        hold = 1'b0;
    logic        timer_source_one;
    logic        timer_source_two;
    logic        high_side_switch_five;
    logic        high_side_switch_six;
    logic [3:0]  pwm_level;
    logic [31:0] lfsr = 32'he3c72b2d;
    int          errors = 0;
    int          check_count = 0;
    logic [6:0]  addrs [8] = '{SRC_SEL_56_ADDR, DUTY_CH1_ADDR, DUTY_CH2_ADDR, DUTY_CH3_ADDR,
                               DUTY_CH4_ADDR, RATE_SEL_ADDR, SCRATCH_ADDR, 7'h17};
    always #12.5 core_clk = ~core_clk;
    high_side_pwm_config i_dut (.*);
    timer_src_model i_timer (.core_clk(core_clk), .hold(hold),
        .timer_one(timer_source_one), .timer_two(timer_source_two));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] mask_of(input logic [6:0] a);
        if (a == SRC_SEL_56_ADDR) return 8'h77;
        if (a == RATE_SEL_ADDR) return 8'h55;
        return (a == 7'h17) ? 8'h00 : 8'hff;
    endfunction
    // duties below are ff, 00, ff, 00 for channels one to four
    function automatic logic exp_sw(input logic [2:0] c);
        logic [3:0] pwm;
        pwm = 4'b0101;
        if (c[2]) return pwm[c[1:0]];
        return (c == 3'h1) || (c == 3'h2 && timer_source_one) || (c == 3'h3 && timer_source_two);
    endfunction
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge core_clk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk) #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(posedge core_clk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk) #1;
        reg_rd = 1'b0;
        check8("reg_rdata", exp, reg_rdata);
    endtask
    task automatic fault_chk(input logic [6:0] f, input logic [7:0] exp);
        wr(SRC_SEL_56_ADDR, 8'h11);
        {overcurrent, overtemp, recovery_en, supply_fault} = f;
        @(posedge core_clk) #1;
        {overcurrent, overtemp, supply_fault} = 5'h00;
        rd_chk(SRC_SEL_56_ADDR, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        #1 srst = 1'b0;
        for (int i = 0; i < 7; i++) rd_chk(addrs[i], 8'h00);
        // random duties are only read back, never timed as pulses
        for (int n = 0; n < 48; n++) begin
            lfsr = next_rand(lfsr);
            wr(addrs[n % 8], lfsr[7:0]);
            rd_chk(addrs[n % 8], lfsr[7:0] & mask_of(addrs[n % 8]));
        end
        wr(DUTY_CH1_ADDR, 8'hff);
        wr(DUTY_CH2_ADDR, 8'h00);
        wr(DUTY_CH3_ADDR, 8'hff);
        wr(DUTY_CH4_ADDR, 8'h00);
        hold = 1'b1;
        // duty lands one edge after the write, the output one edge later
        repeat (2) @(posedge core_clk) #1;
        check8("pwm_level", 8'h05, {4'h0, pwm_level});
        for (int c = 0; c < 8; c++) begin
            wr(SRC_SEL_56_ADDR, {1'b1, 3'(7 - c), 1'b1, 3'(c)});
            repeat (2) @(posedge core_clk) #1;
            check8("switch_five", {7'h0, exp_sw(3'(c))}, {7'h0, high_side_switch_five});
            check8("switch_six", {7'h0, exp_sw(3'(7 - c))}, {7'h0, high_side_switch_six});
        end
        hold = 1'b0;
        wr(SRC_SEL_56_ADDR, 8'h88);
        rd_chk(SRC_SEL_56_ADDR, 8'h00);
        fault_chk(7'b0100000, 8'h10);
        fault_chk(7'b0010000, 8'h01);
        fault_chk(7'b0000011, 8'h01);
        fault_chk(7'b0000111, 8'h11);
        wr(SCRATCH_ADDR, 8'h5a);
        normal_mode = 1'b0;
        wr(SCRATCH_ADDR, 8'ha5);
        rd_chk(SCRATCH_ADDR, 8'h00);
        normal_mode = 1'b1;
        rd_chk(SCRATCH_ADDR, 8'h5a);
        wr(DUTY_CH4_ADDR, 8'h3c);
        wr(RATE_SEL_ADDR, 8'hff);
        restart_mode = 1'b1;
        repeat (3) @(posedge core_clk) #1;
        restart_mode = 1'b0;
        rd_chk(DUTY_CH4_ADDR, 8'h3c);
        rd_chk(RATE_SEL_ADDR, 8'h55);
        rd_chk(SCRATCH_ADDR, 8'h5a);
        rd_chk(SRC_SEL_56_ADDR, 8'h00);
        srst = 1'b1;
        repeat (2) @(posedge core_clk) #1;
        srst = 1'b0;
        rd_chk(SCRATCH_ADDR, 8'h00);
        rd_chk(DUTY_CH4_ADDR, 8'h00);
        // counters restart at reset: duty 2 ends near step 2, slow rate twice as late
        wr(DUTY_CH1_ADDR, 8'h02);
        wr(DUTY_CH2_ADDR, 8'h02);
        wr(RATE_SEL_ADDR, 8'h04);
        check8("pwm_level", 8'h03, {4'h0, pwm_level});
        repeat (1560) @(posedge core_clk) #1;
        check8("pwm_level", 8'h01, {4'h0, pwm_level});
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        end_of_test();
    end
endmodule // test_high_side_pwm_config
